/* File: dv/pwec_node_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pwec_node_model (
  input  wire logic        CLOCK,
  output logic             FAIL_VALID,
  output logic [9:0]       FAIL_BUS,
  output logic [5:0]       FAIL_NODE,
  output logic [47:0]      FAIL_OFFSET
);
  initial {FAIL_VALID, FAIL_BUS, FAIL_NODE, FAIL_OFFSET} = '0;
  // call right after an edge; more keeps valid up for a back-to-back failure
  task automatic send(input pwec_pkg::pwec_fail_t f, input logic more);
    FAIL_VALID <= 1'b1;
    {FAIL_BUS, FAIL_NODE, FAIL_OFFSET} <= f;
    @(posedge CLOCK);
    if (!more) begin
      FAIL_VALID <= 1'b0;
      // stale fields inverted so a late capture cannot look correct
      {FAIL_BUS, FAIL_NODE, FAIL_OFFSET} <= ~f;
      repeat (2) @(posedge CLOCK);
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/test_posted_write_error_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module test_posted_write_error_capture;
  logic        CLOCK = 1'b0, RST_N = 1'b0, CE = 1'b1, IRQ, ARREADY;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, BVALID;
  logic        ARVALID = 1'b0, RREADY = 1'b0, RVALID, AWREADY, WREADY;
  logic [7:0]  AWADDR = 8'h0, ARADDR = 8'h0;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0]  WSTRB = 4'hf;
  logic [1:0]  BRESP, RRESP;
  logic        FAIL_VALID;
  logic [9:0]  FAIL_BUS;
  logic [5:0]  FAIL_NODE;
  logic [47:0] FAIL_OFFSET;
  int          mismatches = 0, checks_done = 0;
  pwec_pkg::pwec_fail_t f1 = '{10'h2a5, 6'h1b, 48'hbeef_1234_5678};
  pwec_pkg::pwec_fail_t f2 = '{10'h3ff, 6'h00, 48'hffff_0000_ffff};
  pwec_pkg::pwec_fail_t f3 = '{10'h001, 6'h3f, 48'h0001_a5a5_5a5a};
  always #10 CLOCK = ~CLOCK;
  pwec_top dut (.CLOCK, .RST_N, .CE, .FAIL_VALID, .FAIL_BUS, .FAIL_NODE,
    .FAIL_OFFSET, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
    .RDATA, .RRESP, .RVALID, .RREADY, .IRQ);
  pwec_node_model node (.CLOCK, .FAIL_VALID, .FAIL_BUS, .FAIL_NODE,
    .FAIL_OFFSET);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait; a hang ends the run as a mismatch
  task automatic wait_hi(ref logic sig);
    int n;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (sig !== 1'b1 && n < 50);
    if (sig !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] bexp = 2'h0);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    fork
      begin wait_hi(AWREADY); AWVALID <= 1'b0; end
      begin wait_hi(WREADY); WVALID <= 1'b0; end
    join
    wait_hi(BVALID);
    BREADY <= 1'b0;
    check("bresp", {30'h0, BRESP}, {30'h0, bexp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] rexp = 2'h0);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    wait_hi(ARREADY);
    ARVALID <= 1'b0;
    wait_hi(RVALID);
    RREADY <= 1'b0;
    check($sformatf("rdata %h", a), RDATA, exp);
    check($sformatf("rresp %h", a), {30'h0, RRESP}, {30'h0, rexp});
  endtask
  task automatic rdf(input pwec_pkg::pwec_fail_t f);
    rd(pwec_pkg::OFS_FAIL_LOW, f.offset[31:0]);
    rd(pwec_pkg::OFS_FAIL_HIGH, {f.bus, f.node, f.offset[47:32]});
  endtask
  initial begin
    repeat (5) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    rd(pwec_pkg::OFS_MAKER_ID, pwec_pkg::MAKER_ID_VALUE);
    wr(pwec_pkg::OFS_MAKER_ID, 32'hffff_ffff);
    rd(pwec_pkg::OFS_MAKER_ID, pwec_pkg::MAKER_ID_VALUE);
    rd(8'h50, 32'h0, pwec_pkg::RESP_SLVERR);
    wr(pwec_pkg::OFS_IRQ_MASK, 32'h1);
    node.send(f1, 1'b0);
    rdf(f1);
    check("irq", {31'h0, IRQ}, 32'h1);
    wr(pwec_pkg::OFS_FAIL_LOW, ~f1[31:0]);
    wr(pwec_pkg::OFS_FAIL_HIGH, ~f1[63:32]);
    rdf(f1);
    rd(pwec_pkg::OFS_IRQ_STAT, 32'h1);
    wr(pwec_pkg::OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge CLOCK);
    check("irq", {31'h0, IRQ}, 32'h0);
    // back-to-back failures: only the later record may survive
    node.send(f2, 1'b1);
    node.send(f3, 1'b0);
    rdf(f3);
    rd(pwec_pkg::OFS_IRQ_STAT, 32'h3);
    check("irq", {31'h0, IRQ}, 32'h1);
    wr(pwec_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge CLOCK);
    check("irq", {31'h0, IRQ}, 32'h0);
    wr(8'h50, 32'h1, pwec_pkg::RESP_SLVERR);
    // a failure while the clock enable is low must not be captured
    CE <= 1'b0;
    node.send(f1, 1'b0);
    CE <= 1'b1;
    rdf(f3);
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: verilog/pwec_pkg.sv */
// What this block does
// - A posted write that fails while its data is written loads its error record into the two failure registers.
// - The low failure register holds the lower 32 bits of the failed destination offset.
// - The high failure register holds the upper 16 offset bits in bits 15 to 0.
// - The high failure register holds the requester's 10-bit bus number in bits 31 to 22.
// - The high failure register holds the requester's 6-bit node number in bits 21 to 16.
// - Both failure registers are read-only to software, loaded only by hardware, undefined after reset.
// - The maker identification register is read-only and always returns the fixed identifier.
`default_nettype none
package pwec_pkg;
  localparam logic [7:0]  OFS_FAIL_LOW  = 8'h38;
  localparam logic [7:0]  OFS_FAIL_HIGH = 8'h3c;
  localparam logic [7:0]  OFS_MAKER_ID  = 8'h40;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h44;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h48;
  // arbitrary neutral identifier value
  localparam logic [31:0] MAKER_ID_VALUE = 32'h00c0_ffee;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          IRQ_BITS    = 2;
  localparam int          IRQ_FAIL    = 0;
  localparam int          IRQ_LOST    = 1;
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 2'h0;

  typedef struct packed {
    logic [9:0]  bus;
    logic [5:0]  node;
    logic [47:0] offset;
  } pwec_fail_t;
endpackage
`default_nettype wire

/* File: verilog/pwec_top.sv */
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module pwec_top (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic        FAIL_VALID,
  input  wire logic [9:0]  FAIL_BUS,
  input  wire logic [5:0]  FAIL_NODE,
  input  wire logic [47:0] FAIL_OFFSET,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             IRQ
);
  localparam int IRQ_BITS_L = pwec_pkg::IRQ_BITS;

  pwec_pkg::pwec_fail_t       rec;
  logic                       rec_valid;
  logic [31:0]                failed_offset_lower_bits;
  logic [15:0]                failed_offset_upper_bits;
  logic [15:0]                requester_bus_and_node;
  logic [31:0]                high_word;
  wire logic [IRQ_BITS_L-1:0] stat;
  logic [IRQ_BITS_L-1:0]      mask;
  logic [IRQ_BITS_L-1:0]      evt;
  logic                       aw_got;
  logic                       w_got;
  logic [7:0]                 aw_addr;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       aw_take;
  logic                       w_take;
  logic                       b_done;
  logic                       wr_fire;
  logic                       ar_take;
  logic                       r_done;
  logic                       stat_clr;
  logic                       mask_wr;

  // decoded for both the read answer and the write response
  function automatic logic mapped(input logic [7:0] a);
    mapped = a == pwec_pkg::OFS_FAIL_LOW || a == pwec_pkg::OFS_FAIL_HIGH ||
             a == pwec_pkg::OFS_MAKER_ID || a == pwec_pkg::OFS_IRQ_STAT ||
             a == pwec_pkg::OFS_IRQ_MASK;
  endfunction

  assign failed_offset_lower_bits = rec.offset[31:0];
  assign failed_offset_upper_bits = rec.offset[47:32];
  assign requester_bus_and_node   = {rec.bus, rec.node};
  assign high_word = {requester_bus_and_node, failed_offset_upper_bits};

  assign aw_take  = AWVALID && AWREADY;
  assign w_take   = WVALID && WREADY;
  assign b_done   = BVALID && BREADY;
  assign ar_take  = ARVALID && ARREADY;
  assign r_done   = RVALID && RREADY;
  assign wr_fire  = aw_got && w_got && !BVALID;
  assign stat_clr = wr_fire && aw_addr == pwec_pkg::OFS_IRQ_STAT
                    && w_strb[0];
  assign mask_wr  = wr_fire && aw_addr == pwec_pkg::OFS_IRQ_MASK
                    && w_strb[0];
  assign evt      = {FAIL_VALID && rec_valid, FAIL_VALID};

  // capture: no reset on the record, contents undefined until a failure
  always_ff @(posedge CLOCK) begin
    if (CE && FAIL_VALID) begin
      rec <= '{bus: FAIL_BUS, node: FAIL_NODE, offset: FAIL_OFFSET};
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rec_valid <= 1'b0;
    end else if (CE && FAIL_VALID) begin
      rec_valid <= 1'b1;
    end
  end

  // one sticky bit per event; an event wins over a same-cycle clear
  for (genvar gi = 0; gi < IRQ_BITS_L; gi++) begin : g_stat
    logic sticky;
    always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
        sticky <= 1'b0;
      end else if (CE) begin
        if (evt[gi]) begin
          sticky <= 1'b1;
        end else if (stat_clr && w_data[gi]) begin
          sticky <= 1'b0;
        end
      end
    end
    assign stat[gi] = sticky;
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mask <= pwec_pkg::IRQ_MASK_RESET;
    end else if (CE && mask_wr) begin
      mask <= w_data[IRQ_BITS_L-1:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= |(stat & mask);
    end
  end

  // write path: address and data taken in either order
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      AWREADY <= 1'b0;
    end else if (CE) begin
      AWREADY <= !aw_got && !aw_take;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      WREADY <= 1'b0;
    end else if (CE) begin
      WREADY <= !w_got && !w_take;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aw_got  <= 1'b0;
      aw_addr <= '0;
    end else if (CE) begin
      if (aw_take) begin
        aw_got  <= 1'b1;
        aw_addr <= AWADDR;
      end else if (b_done) begin
        aw_got  <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      w_got  <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (CE) begin
      if (w_take) begin
        w_got  <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end else if (b_done) begin
        w_got  <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      BVALID <= 1'b0;
      BRESP  <= pwec_pkg::RESP_OKAY;
    end else if (CE) begin
      if (wr_fire) begin
        BVALID <= 1'b1;
        // failure and identity registers ignore writes
        BRESP  <= mapped(aw_addr) ? pwec_pkg::RESP_OKAY
                                  : pwec_pkg::RESP_SLVERR;
      end else if (b_done) begin
        BVALID <= 1'b0;
      end
    end
  end

  // read path: one read outstanding, address refused while data stands
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ARREADY <= 1'b0;
    end else if (CE) begin
      ARREADY <= !RVALID && !ar_take;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RVALID <= 1'b0;
    end else if (CE) begin
      if (ar_take) begin
        RVALID <= 1'b1;
      end else if (r_done) begin
        RVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= '0;
      RRESP <= pwec_pkg::RESP_OKAY;
    end else if (CE && ar_take) begin
      RRESP <= mapped(ARADDR) ? pwec_pkg::RESP_OKAY
                              : pwec_pkg::RESP_SLVERR;
      case (ARADDR)
        pwec_pkg::OFS_FAIL_LOW:  RDATA <= failed_offset_lower_bits;
        pwec_pkg::OFS_FAIL_HIGH: RDATA <= high_word;
        pwec_pkg::OFS_MAKER_ID:  RDATA <= pwec_pkg::MAKER_ID_VALUE;
        pwec_pkg::OFS_IRQ_STAT:  RDATA <= {{(32-IRQ_BITS_L){1'b0}}, stat};
        pwec_pkg::OFS_IRQ_MASK:  RDATA <= {{(32-IRQ_BITS_L){1'b0}}, mask};
        default:                 RDATA <= 32'h0;
      endcase
    end
  end

  // bus steps shared by the checks below
  sequence s_read_take(logic [7:0] ofs);
    CE && ar_take && ARADDR == ofs;
  endsequence

  sequence s_write_land(logic [7:0] ofs);
    CE && wr_fire && aw_addr == ofs;
  endsequence

  sequence s_read_waits;
    RVALID && !RREADY;
  endsequence

  a_fail_capture: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    CE && FAIL_VALID |=> rec.offset == $past(FAIL_OFFSET)
      && rec.bus == $past(FAIL_BUS) && rec.node == $past(FAIL_NODE))
    else $error("failure record not loaded");
  a_fail_flag: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    CE && FAIL_VALID |=> stat[pwec_pkg::IRQ_FAIL])
    else $error("failure flag not set");
  a_high_layout: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    s_read_take(pwec_pkg::OFS_FAIL_HIGH) ##0 rec_valid
      |=> RDATA[31:22] == $past(rec.bus))
    else $error("bus number field wrong");
  a_node_field: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    s_read_take(pwec_pkg::OFS_FAIL_HIGH) ##0 rec_valid
      |=> RDATA[21:16] == $past(rec.node))
    else $error("node field wrong");
  a_hi_read: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    s_read_take(pwec_pkg::OFS_FAIL_HIGH) ##0 rec_valid
      |=> RDATA[15:0] == $past(rec.offset[47:32]))
    else $error("high read wrong");
  a_low_read: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    s_read_take(pwec_pkg::OFS_FAIL_LOW) ##0 rec_valid
      |=> RDATA == $past(rec.offset[31:0]))
    else $error("low read wrong");
  a_id_read: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    s_read_take(pwec_pkg::OFS_MAKER_ID)
      |=> RVALID && RDATA == pwec_pkg::MAKER_ID_VALUE)
    else $error("identifier read wrong");
  a_id_write: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    s_write_land(pwec_pkg::OFS_MAKER_ID)
      |=> BVALID && BRESP == pwec_pkg::RESP_OKAY)
    else $error("identifier write answered wrongly");
  a_record_hold: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    rec_valid && !(CE && FAIL_VALID) |=> $stable(rec))
    else $error("record changed without failure");
  a_ro_write: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    CE && wr_fire && (aw_addr == pwec_pkg::OFS_FAIL_LOW
      || aw_addr == pwec_pkg::OFS_FAIL_HIGH) && rec_valid && !FAIL_VALID
      |=> BVALID && BRESP == pwec_pkg::RESP_OKAY && $stable(rec))
    else $error("failure register took a write");
  a_record_whole: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    CE && FAIL_VALID ##1 CE && FAIL_VALID |=> rec.node == $past(FAIL_NODE)
      && rec.bus == $past(FAIL_BUS) && rec.offset == $past(FAIL_OFFSET))
    else $error("newer failure not loaded whole");
  a_lost_flag: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    CE && FAIL_VALID && rec_valid |=> stat[pwec_pkg::IRQ_LOST])
    else $error("overwrite flag not set");

  a_flag_clear: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    s_write_land(pwec_pkg::OFS_IRQ_STAT) ##0 (w_strb[0]
      && w_data[pwec_pkg::IRQ_FAIL] && !FAIL_VALID)
      |=> !stat[pwec_pkg::IRQ_FAIL])
    else $error("failure flag not cleared");
  a_flag_sticky: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    stat[pwec_pkg::IRQ_FAIL] && !(CE && stat_clr)
      |=> stat[pwec_pkg::IRQ_FAIL])
    else $error("failure flag dropped by itself");
  a_lost_sticky: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    stat[pwec_pkg::IRQ_LOST] && !(CE && stat_clr)
      |=> stat[pwec_pkg::IRQ_LOST])
    else $error("overwrite flag dropped by itself");
  a_mask_load: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    s_write_land(pwec_pkg::OFS_IRQ_MASK) ##0 w_strb[0]
      |=> mask == $past(w_data[IRQ_BITS_L-1:0]))
    else $error("mask not loaded");
  a_irq_level: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    CE |=> IRQ == $past(|(stat & mask)))
    else $error("interrupt does not follow status");
  a_irq_masked: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    CE && mask == '0 |=> !IRQ)
    else $error("interrupt raised while all masked");

  a_bad_read: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    CE && ar_take && !mapped(ARADDR) |=> RVALID
      && RRESP == pwec_pkg::RESP_SLVERR && RDATA == 32'h0)
    else $error("unmapped read answered wrongly");
  a_bad_write: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    CE && wr_fire && !mapped(aw_addr)
      |=> BVALID && BRESP == pwec_pkg::RESP_SLVERR)
    else $error("unmapped write answered wrongly");
  a_read_answer: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    CE && ar_take |=> RVALID)
    else $error("read not answered");
  a_write_answer: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    CE && wr_fire |=> BVALID)
    else $error("write not answered");
  a_rdata_stands: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    s_read_waits |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read answer withdrawn early");
  a_bresp_stands: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write answer withdrawn early");
  a_ar_busy: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    RVALID |-> !ARREADY)
    else $error("read address taken while busy");
  a_aw_busy: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    aw_got |-> !AWREADY)
    else $error("write address taken while busy");
  a_w_busy: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    w_got |-> !WREADY)
    else $error("write data taken while busy");
  // the record is covered by a_record_hold, which needs it loaded first
  a_frozen: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    !CE |=> $stable(stat) && $stable(mask) && $stable(IRQ)
      && $stable(RVALID) && $stable(BVALID) && $stable(rec_valid))
    else $error("state moved while clock enable low");
endmodule
`default_nettype wire
